// [hw/rtc_wakeup_core.sv]
/*
  rtc_wakeup_core: bcd clock/calendar with access freeze, wakeup down-counter and
  interrupt pin routing, behind a simple strobe register port.
  assumes the serial engine (same clock) raises host_access_i for a whole transfer,
  and that timebase_i and freq_output_signal_i are asynchronous.
*/
// The strobed register port is this design's own decision.
// Summary of operation
// - frequency output goes to pin a (00) or pin b (01) per the two route bits; 10 and 11 drive neither
// - wakeup interrupt goes to pin a or b per the timer route bit
// - write-prohibited bits ignore writes and read back zero
// - time frozen during host access; deferred seconds applied afterwards
// - seconds and minutes are bcd modulo-60 with carry at 59 to 00
// - writing seconds clears the 512 Hz to 1 Hz divider stages
// - hours are bcd modulo-24, advanced by the minute carry
// - weekday is one-hot, rotates 01h to 40h on hour carry, no carry out
// - day length 28 to 31 by month and leap year
// - month is bcd modulo-12, advanced by the day carry
// - year is bcd 00 to 99; leap year derived from it
// - periodic wakeup event; pin released automatically after each one
// - 16-bit preset, low byte at 1b, high byte at 1c, counts 1 to 65535
// - timer registers read preset when disabled, live count when enabled
// - source select picks 4096 Hz, 64 Hz, 1 Hz, per minute or per hour
// - pin low 122 us with 4096 Hz source, 7.813 ms otherwise
// - first countdown period may be short by up to one source period
// - enable rising starts from preset; clearing enable keeps pin low
// - event sets timer flag until host writes zero; writing one does nothing
// - pin driven only with interrupt enable; clearing it releases the pin
// - timer pause holds the count; resume continues from held value
`timescale 1ns/10ps
module rtc_wakeup_core
  import rtc_pkg::*;
#(
  parameter int RTN_SHORT_CYC = (RTN_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS,
  parameter int RTN_LONG_CYC = (RTN_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
) (
  input logic clk_sys_i,
  input logic rst_i,
  input logic [7:0] reg_addr_i,
  input logic [7:0] reg_wdata_i,
  input logic reg_wr_i,
  input logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input logic timebase_i,
  input logic host_access_i,
  input logic freq_output_signal_i,
  output logic interrupt_pin_a_o,
  output logic interrupt_pin_a_oe_o,
  output logic interrupt_pin_b_o,
  output logic interrupt_pin_b_oe_o
);
  // ********************************************************************
  // helpers
  // ********************************************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == BCD_NINE) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction : bcd_inc

  // ********************************************************************
  // input synchronisers
  // ********************************************************************
  logic tb_s1, tb_s2, tb_s3, fo_s1, fo_s2;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      {tb_s1, tb_s2, tb_s3, fo_s1, fo_s2} <= 5'h00;
    end else begin
      {tb_s1, tb_s2, tb_s3} <= {timebase_i, tb_s1, tb_s2};
      {fo_s1, fo_s2} <= {freq_output_signal_i, fo_s1};
    end
  end
  wire logic tick = tb_s2 && !tb_s3;

  // ********************************************************************
  // register decode
  // ********************************************************************
  wire logic w_sec = reg_wr_i && (reg_addr_i == A_SEC);
  wire logic w_min = reg_wr_i && (reg_addr_i == A_MIN);
  wire logic w_hour = reg_wr_i && (reg_addr_i == A_HOUR);
  wire logic w_wday = reg_wr_i && (reg_addr_i == A_WDAY);
  wire logic w_day = reg_wr_i && (reg_addr_i == A_DAY);
  wire logic w_mon = reg_wr_i && (reg_addr_i == A_MON);
  wire logic w_year = reg_wr_i && (reg_addr_i == A_YEAR);
  wire logic w_flg = reg_wr_i && (reg_addr_i == A_FLG);

  logic [7:0] rsv_a, rsv_b, ext_reg, ctl_reg, irq_reg;
  logic [15:0] preset;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      {rsv_a, rsv_b, ext_reg, ctl_reg, irq_reg} <= '0;
      preset <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == A_RSV_A) rsv_a <= reg_wdata_i;
      if (reg_addr_i == A_RSV_B) rsv_b <= reg_wdata_i & M_RSV_B;
      if (reg_addr_i == A_IRQ) irq_reg <= reg_wdata_i & M_IRQ;
      if (reg_addr_i == A_EXT) ext_reg <= reg_wdata_i;
      if (reg_addr_i == A_CTL) ctl_reg <= reg_wdata_i;
      if (reg_addr_i == A_TPL) preset[7:0] <= reg_wdata_i;
      if (reg_addr_i == A_TPH) preset[15:8] <= reg_wdata_i;
    end
  end
  wire logic te = ext_reg[EXT_TE];
  wire logic [2:0] tsel = ext_reg[EXT_TSEL_MSB:0];
  wire logic stop = ctl_reg[CTL_STOP];
  wire logic wake_irq_enable = ctl_reg[CTL_TIE];
  wire logic wake_count_pause = ctl_reg[CTL_WAKE_COUNT_PAUSE];
  wire logic wake_irq_route_sel = irq_reg[IRQ_WAKE_IRQ_ROUTE_SEL];
  wire logic [1:0] fo_sel = irq_reg[IRQ_FO_MSB:0];

  // ********************************************************************
  // sub-second divider
  // ********************************************************************
  logic [DIV_W-1:0] div;
  wire logic [DIV_W-1:0] div_inc = tick ? div + 15'h0001 : div;
  wire logic [DIV_W-1:0] next_div = w_sec ? (div_inc & DIV_KEEP) : div_inc;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) div <= '0;
    else div <= next_div;
  end
  // stop freezes every source except 4096 Hz, which keeps the pin timing alive
  wire logic tick4096 = tick && ((div & DIV_4096) == DIV_4096);
  wire logic tick64 = tick && !stop && ((div & DIV_64) == DIV_64);
  wire logic sec_tick = tick && !stop && (div == DIV_1HZ);

  // ********************************************************************
  // access freeze: seconds seen during a transfer wait in a small backlog
  // ********************************************************************
  logic [PEND_W-1:0] pend;
  wire logic step = (pend != '0) && !host_access_i;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) pend <= '0;
    else if (sec_tick && !step && !(&pend)) pend <= pend + 3'h1;
    else if (step && !sec_tick) pend <= pend - 3'h1;
  end

  // ********************************************************************
  // clock and calendar counters
  // ********************************************************************
  rtc_time_t tm, next_tm;
  logic [7:0] dlast;
  wire logic [3:0] ly = tm.year[3:0] + {2'h0, tm.year[4], 1'b0};
  wire logic leap = (ly[1:0] == 2'h0);
  always_comb begin
    case (tm.mon)
      MON_FEB: dlast = leap ? DAYS_29 : DAYS_28;
      MON_APR, MON_JUN, MON_SEP, MON_NOV: dlast = DAYS_30;
      default: dlast = DAYS_31;
    endcase
  end
  wire logic c_sec = step && (tm.sec == BCD_59);
  wire logic c_min = c_sec && (tm.min == BCD_59);
  wire logic c_hr = c_min && (tm.hour == BCD_23);
  wire logic c_day = c_hr && (tm.day == dlast);
  wire logic c_mon = c_day && (tm.mon == BCD_12);

  always_comb begin
    next_tm = tm;
    if (step) next_tm.sec = c_sec ? '0 : bcd_inc(tm.sec);
    if (c_sec) next_tm.min = c_min ? '0 : bcd_inc(tm.min);
    if (c_min) next_tm.hour = c_hr ? '0 : bcd_inc(tm.hour);
    if (c_hr) next_tm.wday = {1'b0, tm.wday[5:0], tm.wday[6]};
    if (c_hr) next_tm.day = c_day ? BCD_01 : bcd_inc(tm.day);
    if (c_day) next_tm.mon = c_mon ? BCD_01 : bcd_inc(tm.mon);
    if (c_mon) next_tm.year = (tm.year == BCD_99) ? '0 : bcd_inc(tm.year);
    if (w_sec) next_tm.sec = reg_wdata_i & M_SEC;
    if (w_min) next_tm.min = reg_wdata_i & M_SEC;
    if (w_hour) next_tm.hour = reg_wdata_i & M_HOUR;
    if (w_wday) next_tm.wday = reg_wdata_i & M_SEC;
    if (w_day) next_tm.day = reg_wdata_i & M_HOUR;
    if (w_mon) next_tm.mon = reg_wdata_i & M_MON;
    if (w_year) next_tm.year = reg_wdata_i;
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) tm <= TIME_RST;
    else tm <= next_tm;
  end

  // ********************************************************************
  // wakeup down-counter
  // ********************************************************************
  logic src_tick;
  always_comb begin
    case (tsel)
      TSEL_4096: src_tick = tick4096;
      TSEL_64: src_tick = tick64;
      TSEL_1HZ: src_tick = sec_tick;
      TSEL_MIN: src_tick = c_sec;
      TSEL_HOUR: src_tick = c_min;
      default: src_tick = 1'b0;
    endcase
  end
  logic te_d, tf;
  logic [15:0] cnt;
  // the divider is not restarted on enable, so the first period can run short
  wire logic te_rise = te && !te_d;
  wire logic run = te && te_d && !wake_count_pause && src_tick;
  wire logic wake_evt = run && (cnt <= 16'h0001);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      te_d <= 1'b0;
      cnt <= '0;
    end else begin
      te_d <= te;
      if (te_rise) cnt <= preset;
      else if (wake_evt) cnt <= preset;
      else if (run) cnt <= cnt - 16'h0001;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) tf <= 1'b0;
    else if (wake_evt) tf <= 1'b1;
    else if (w_flg && !reg_wdata_i[FLG_TF]) tf <= 1'b0;
  end

  // ********************************************************************
  // interrupt pin hold and automatic release
  // ********************************************************************
  rtc_pin_st_t pin_st;
  logic [RTN_W-1:0] rtn;
  wire logic [RTN_W-1:0] rtn_load =
    (tsel == TSEL_4096) ? RTN_W'(RTN_SHORT_CYC) : RTN_W'(RTN_LONG_CYC);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_st <= RTC_PIN_IDLE;
      rtn <= '0;
    end else begin
      case (pin_st)
        RTC_PIN_IDLE: begin
          if (wake_evt && wake_irq_enable) begin
            pin_st <= RTC_PIN_LOW;
            rtn <= rtn_load;
          end
        end
        RTC_PIN_LOW: begin
          if (!wake_irq_enable) pin_st <= RTC_PIN_IDLE;
          else if (wake_evt) rtn <= rtn_load;
          else if (rtn <= RTN_W'(1)) pin_st <= RTC_PIN_IDLE;
          else rtn <= rtn - RTN_W'(1);
        end
        default: pin_st <= RTC_PIN_IDLE;
      endcase
    end
  end

  // ********************************************************************
  // pin routing: both pins open-drain, only ever pulled low
  // ********************************************************************
  wire logic wk_low = (pin_st == RTC_PIN_LOW);
  wire logic fo_low = !fo_s2;
  wire logic drv_a = (wk_low && wake_irq_route_sel) || (fo_low && fo_sel == FO_PIN_A);
  wire logic drv_b = (wk_low && !wake_irq_route_sel) || (fo_low && fo_sel == FO_PIN_B);
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      {interrupt_pin_a_o, interrupt_pin_a_oe_o} <= 2'h0;
      {interrupt_pin_b_o, interrupt_pin_b_oe_o} <= 2'h0;
    end else begin
      interrupt_pin_a_oe_o <= drv_a;
      interrupt_pin_b_oe_o <= drv_b;
    end
  end

  // ********************************************************************
  // read path
  // ********************************************************************
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    case (reg_addr_i)
      A_SEC: rd_val = tm.sec;
      A_MIN: rd_val = tm.min;
      A_HOUR: rd_val = tm.hour;
      A_WDAY: rd_val = tm.wday;
      A_DAY: rd_val = tm.day;
      A_MON: rd_val = tm.mon;
      A_YEAR: rd_val = tm.year;
      A_RSV_A: rd_val = rsv_a;
      A_TPL: rd_val = te ? cnt[7:0] : preset[7:0];
      A_TPH: rd_val = te ? cnt[15:8] : preset[15:8];
      A_EXT: rd_val = ext_reg;
      A_FLG: rd_val[FLG_TF] = tf;
      A_CTL: rd_val = ctl_reg;
      A_RSV_B: rd_val = rsv_b;
      A_IRQ: rd_val = irq_reg;
      default: rd_val = 8'h00;
    endcase
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) reg_rdata_o <= 8'h00;
    else reg_rdata_o <= reg_rd_i ? rd_val : 8'h00;
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  AST_SEC_WRAP: assert property (
    c_sec && !w_sec |=> tm.sec == 8'h00 && $past(tm.min) != tm.min || $past(w_min))
    else $error("seconds did not wrap with carry");
  AST_FREEZE: assert property (
    host_access_i && !w_sec && !w_min |=> $stable(tm.sec) && $stable(tm.min))
    else $error("time moved during host access");
  AST_DIV_CLR: assert property (
    w_sec |=> (div & ~DIV_KEEP) == '0)
    else $error("divider not cleared by seconds write");
  AST_TE_LOAD: assert property (
    te_rise |=> cnt == $past(preset))
    else $error("enable rise did not load preset");
  AST_RELOAD: assert property (
    wake_evt && !te_rise |=> cnt == $past(preset) && tf)
    else $error("terminal count did not reload and flag");
  AST_PAUSE: assert property (
    te && te_d && wake_count_pause && $stable(ext_reg) |=> $stable(cnt))
    else $error("count moved while paused");
  AST_FLAG_W1: assert property (
    tf && w_flg && reg_wdata_i[FLG_TF] |=> tf)
    else $error("writing one cleared the flag");
  AST_TIE_OFF: assert property (
    wk_low && !wake_irq_enable |=> pin_st == RTC_PIN_IDLE ##1 !(interrupt_pin_a_oe_o && wake_irq_route_sel && !drv_a))
    else $error("pin held after interrupt enable cleared");
  AST_ROUTE: assert property (
    wk_low && wake_irq_route_sel |=> interrupt_pin_a_oe_o)
    else $error("wakeup interrupt not on pin a");
  AST_RD_PRESET: assert property (
    reg_rd_i && reg_addr_i == A_TPL && !te |=> reg_rdata_o == $past(preset[7:0]))
    else $error("disabled timer read did not return preset");
  // calendar wrap and leap checks
  AST_HOUR_WRAP: assert property (
    c_hr && !w_hour |=> tm.hour == 8'h00)
    else $error("hours did not wrap at midnight");
  AST_WDAY_ROT: assert property (
    c_hr && !w_wday |=> tm.wday == {1'b0, $past(tm.wday[5:0]), $past(tm.wday[6])})
    else $error("weekday did not rotate on hour carry");
  AST_DAY_WRAP: assert property (
    c_day && !w_day |=> tm.day == BCD_01)
    else $error("day did not wrap to the first");
  AST_FEB_LEAP: assert property (
    tm.mon == MON_FEB && tm.year[1:0] == 2'h0 && !tm.year[4] |-> dlast == DAYS_29)
    else $error("leap year february not 29 days");
  AST_MON_WRAP: assert property (
    c_mon && !w_mon |=> tm.mon == BCD_01)
    else $error("month did not wrap to the first");
  AST_YEAR_WRAP: assert property (
    c_mon && !w_year && tm.year == BCD_99 |=> tm.year == 8'h00)
    else $error("year did not wrap after 99");
  // timer and pin checks
  AST_SRC_NONE: assert property (
    tsel > TSEL_HOUR |-> !src_tick)
    else $error("unused source select produced a tick");
  AST_RTN_LOAD: assert property (
    pin_st == RTC_PIN_IDLE && wake_evt && wake_irq_enable |=> wk_low && rtn == $past(rtn_load))
    else $error("release time not loaded on event");
  AST_AUTO_REL: assert property (
    wk_low && wake_irq_enable && !wake_evt && rtn <= RTN_W'(1) |=> !wk_low)
    else $error("pin not released after release time");
  AST_TE_OFF_HOLD: assert property (
    wk_low && wake_irq_enable && !te && rtn > RTN_W'(1) |=> wk_low)
    else $error("clearing timer enable released the pin");
  AST_NO_IRQ: assert property (
    !wk_low && !wake_irq_enable |=> !wk_low)
    else $error("pin pulled low with interrupt disabled");
  AST_FO_ROUTE: assert property (
    fo_low && fo_sel == FO_PIN_B |=> interrupt_pin_b_oe_o)
    else $error("frequency output not on pin b");
  AST_RD_LIVE: assert property (
    reg_rd_i && reg_addr_i == A_TPH && te |=> reg_rdata_o == $past(cnt[15:8]))
    else $error("enabled timer read did not return live count");
  AST_RD_ZERO: assert property (
    reg_rd_i && reg_addr_i == A_FLG |=> (reg_rdata_o & ~(8'h01 << FLG_TF)) == 8'h00)
    else $error("prohibited flag bits read non-zero");
endmodule : rtc_wakeup_core

// [inc/rtc_pkg.sv]
/*
  rtc_pkg: register map, field positions, bcd limits, timebase and release timing
  shared by the calendar / wakeup timer core.
  assumes a 40 MHz system clock and a 32768 Hz timebase sampled by it.
*/
package rtc_pkg;
  // ********************************************************************
  // register offsets
  // ********************************************************************
  localparam logic [7:0] A_SEC = 8'h10;
  localparam logic [7:0] A_MIN = 8'h11;
  localparam logic [7:0] A_HOUR = 8'h12;
  localparam logic [7:0] A_WDAY = 8'h13;
  localparam logic [7:0] A_DAY = 8'h14;
  localparam logic [7:0] A_MON = 8'h15;
  localparam logic [7:0] A_YEAR = 8'h16;
  localparam logic [7:0] A_RSV_A = 8'h17;
  localparam logic [7:0] A_TPL = 8'h1b;
  localparam logic [7:0] A_TPH = 8'h1c;
  localparam logic [7:0] A_EXT = 8'h1d;
  localparam logic [7:0] A_FLG = 8'h1e;
  localparam logic [7:0] A_CTL = 8'h1f;
  localparam logic [7:0] A_RSV_B = 8'h31;
  localparam logic [7:0] A_IRQ = 8'h32;
  // ********************************************************************
  // field positions and writable masks
  // ********************************************************************
  localparam int EXT_TE = 4;
  localparam int EXT_TSEL_MSB = 2;
  localparam int FLG_TF = 4;
  localparam int CTL_STOP = 6;
  localparam int CTL_TIE = 4;
  localparam int CTL_WAKE_COUNT_PAUSE = 2;
  localparam int IRQ_WAKE_IRQ_ROUTE_SEL = 2;
  localparam int IRQ_FO_MSB = 1;
  localparam logic [7:0] M_SEC = 8'h7f;
  localparam logic [7:0] M_HOUR = 8'h3f;
  localparam logic [7:0] M_MON = 8'h1f;
  localparam logic [7:0] M_RSV_B = 8'h1f;
  localparam logic [7:0] M_IRQ = 8'h77;
  localparam logic [1:0] FO_PIN_A = 2'h0;
  localparam logic [1:0] FO_PIN_B = 2'h1;
  // ********************************************************************
  // sources, divider, bcd limits
  // ********************************************************************
  localparam logic [2:0] TSEL_4096 = 3'h0;
  localparam logic [2:0] TSEL_64 = 3'h1;
  localparam logic [2:0] TSEL_1HZ = 3'h2;
  localparam logic [2:0] TSEL_MIN = 3'h3;
  localparam logic [2:0] TSEL_HOUR = 3'h4;
  localparam int DIV_W = 15;
  localparam logic [14:0] DIV_KEEP = 15'h001f;
  localparam logic [14:0] DIV_4096 = 15'h0007;
  localparam logic [14:0] DIV_64 = 15'h01ff;
  localparam logic [14:0] DIV_1HZ = 15'h7fff;
  localparam logic [3:0] BCD_NINE = 4'h9;
  localparam logic [7:0] BCD_01 = 8'h01;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;
  localparam logic [7:0] DAYS_28 = 8'h28;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_31 = 8'h31;
  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int RTN_SHORT_NS = 122000;
  localparam int RTN_LONG_NS = 7813000;
  localparam int RTN_W = 19;
  localparam int PEND_W = 3;
  // ********************************************************************
  // types
  // ********************************************************************
  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] wday;
    logic [7:0] day;
    logic [7:0] mon;
    logic [7:0] year;
  } rtc_time_t;
  localparam rtc_time_t TIME_RST = 56'h00_00_00_01_01_01_00;
  typedef enum logic {RTC_PIN_IDLE, RTC_PIN_LOW} rtc_pin_st_t;
endpackage : rtc_pkg

// [sim/rtc_host_model.sv]
/*
  rtc_host_model: host side of the register port, bus tasks and init sequence.
  assumes the core samples strobes on the rising edge of clk_sys_i.
*/
`timescale 1ns/10ps
module rtc_host_model
  import rtc_pkg::*;
(
  input logic clk_sys_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic host_access_o
);
  // ********************************************************************
  // bus tasks
  // ********************************************************************
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    host_access_o = 1'b0;
  end
  // released lines show the inverse so stale values never look valid
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] a);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
  endtask : read_reg
  task automatic access(input logic v);
    @(posedge clk_sys_i);
    host_access_o <= v;
  endtask : access
  task automatic init_regs();
    write_reg(A_RSV_A, 8'hd8);
    write_reg(A_CTL, 8'h00);
    write_reg(A_RSV_B, 8'h08);
    write_reg(A_IRQ, 8'h00);
  endtask : init_regs
  // whole set in one transfer, weekday one-hot and matching the date
  task automatic set_time(input rtc_time_t t);
    access(1'b1);
    write_reg(A_SEC, t.sec);
    write_reg(A_MIN, t.min);
    write_reg(A_HOUR, t.hour);
    write_reg(A_WDAY, t.wday);
    write_reg(A_DAY, t.day);
    write_reg(A_MON, t.mon);
    write_reg(A_YEAR, t.year);
    access(1'b0);
  endtask : set_time
endmodule : rtc_host_model

// [sim/tb.sv]
/*
  tb: self-checking bench for rtc_wakeup_core with a host model on the register port.
  assumes a 25 ns clock; release times shortened by parameter.
*/
`timescale 1ns/10ps
module tb;
  import rtc_pkg::*;
  // ********************************************************************
  // signals
  // ********************************************************************
  localparam int SHORT_CYC = 20;
  localparam int LONG_CYC = 40;
  localparam logic [7:0] RA [6] = '{A_MIN, A_HOUR, A_DAY, A_MON, A_RSV_B, A_IRQ};
  localparam logic [7:0] RM [6] = '{8'h7f, M_HOUR, 8'h3f, M_MON, M_RSV_B, M_IRQ};
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic timebase = 1'b0;
  logic tb_fast = 1'b0;
  logic freq_sig = 1'b1;
  logic rd_seen = 1'b0;
  logic [7:0] addr, wdata, rdata;
  logic wr, rd_s, access, pa, pa_oe, pb, pb_oe;
  logic [15:0] exp_q [$];
  int fail_count = 0;
  int cmp_count = 0;
  wire irq_a_n = pa_oe ? pa : 1'b1;
  wire irq_b_n = pb_oe ? pb : 1'b1;
  always #12.5 clk_sys_i = ~clk_sys_i;
  // 200 ns timebase; 50 ns in the calendar phase so one second fits the run
  initial begin
    #7;
    forever #(tb_fast ? 25 : 100) timebase = ~timebase;
  end
  rtc_host_model host (.clk_sys_i(clk_sys_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .reg_wr_o(wr), .reg_rd_o(rd_s), .host_access_o(access));
  rtc_wakeup_core #(.RTN_SHORT_CYC(SHORT_CYC), .RTN_LONG_CYC(LONG_CYC)) dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .timebase_i(timebase),
    .host_access_i(access), .freq_output_signal_i(freq_sig),
    .interrupt_pin_a_o(pa), .interrupt_pin_a_oe_o(pa_oe),
    .interrupt_pin_b_o(pb), .interrupt_pin_b_oe_o(pb_oe));
  // ********************************************************************
  // checking
  // ********************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  always @(posedge clk_sys_i) rd_seen <= rd_s;
  always @(negedge clk_sys_i) begin
    if (rd_seen && exp_q.size() > 0) check({8'h00, rdata}, exp_q.pop_front());
  end
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({8'h00, e});
    host.read_reg(a);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc
  function automatic logic pin(input bit b);
    return ~(b ? irq_b_n : irq_a_n);
  endfunction : pin
  task automatic rise(input bit b);
    int i;
    for (i = 0; i < 9000 && pin(b) === 1'b1; i++) @(negedge clk_sys_i);
    for (i = 0; i < 9000 && pin(b) !== 1'b1; i++) @(negedge clk_sys_i);
  endtask : rise
  task automatic pulse(input bit b, output int gap, output int wid);
    time t0;
    wid = 0;
    rise(b);
    t0 = $time;
    while (pin(b) === 1'b1 && wid < 500) begin
      @(negedge clk_sys_i);
      wid++;
    end
    rise(b);
    gap = int'(($time - t0) / 25);
  endtask : pulse
  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(negedge clk_sys_i);
      seen = seen | pin(1'b0) | pin(1'b1);
    end
    check({15'h0000, seen}, 16'h0000);
  endtask : quiet
  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up
  // ********************************************************************
  // scenarios
  // ********************************************************************
  initial begin
    #2400000;
    fail_count++;
    wrap_up();
  end
  initial begin
    logic [7:0] v;
    int gap, wid, i;
    v = 8'($urandom(65010));
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    host.init_regs();
    rd(A_SEC, 8'h00);
    rd(A_WDAY, 8'h01);
    rd(A_MON, 8'h01);
    rd(A_RSV_A, 8'hd8);
    rd(A_RSV_B, 8'h08);
    rd(8'h20, 8'h00);
    for (i = 0; i < 6; i++) begin
      v = 8'($urandom);
      host.write_reg(RA[i], v);
      rd(RA[i], v & RM[i]);
    end
    host.write_reg(A_FLG, 8'hff);
    rd(A_FLG, 8'h00);
    for (i = 0; i < 3; i++) begin
      host.write_reg(A_IRQ, 8'(i));
      freq_sig <= 1'b0;
      cyc(6);
      check({15'h0000, pin(1'b0)}, {15'h0000, i == 0});
      check({15'h0000, pin(1'b1)}, {15'h0000, i == 1});
      freq_sig <= 1'b1;
      cyc(6);
    end
    // wakeup at 4096 Hz on pin a, preset 2
    host.write_reg(A_EXT, 8'h00);
    host.write_reg(A_TPL, 8'h02);
    host.write_reg(A_TPH, 8'h00);
    rd(A_TPL, 8'h02);
    host.write_reg(A_CTL, 8'h10);
    host.write_reg(A_IRQ, 8'h04);
    host.write_reg(A_EXT, 8'h10);
    pulse(1'b0, gap, wid);
    check(16'(gap), 16'd128);
    check(16'(wid), 16'(SHORT_CYC));
    check({15'h0000, pin(1'b1)}, 16'h0000);
    // drop the interrupt enable while the pin is still held low
    host.write_reg(A_CTL, 8'h00);
    cyc(3);
    check({15'h0000, pin(1'b0)}, 16'h0000);
    host.write_reg(A_CTL, 8'h10);
    rd(A_FLG, 8'h10);
    host.write_reg(A_EXT, 8'h00);
    host.write_reg(A_FLG, 8'hff);
    rd(A_FLG, 8'h10);
    host.write_reg(A_FLG, 8'h00);
    rd(A_FLG, 8'h00);
    // wakeup at 64 Hz on pin b, preset 1
    host.write_reg(A_TPL, 8'h01);
    host.write_reg(A_IRQ, 8'h00);
    host.write_reg(A_EXT, 8'h11);
    pulse(1'b1, gap, wid);
    check(16'(gap), 16'd4096);
    check(16'(wid), 16'(LONG_CYC));
    cyc(LONG_CYC + 5);
    host.write_reg(A_CTL, 8'h14);
    quiet(5000);
    host.write_reg(A_FLG, 8'h00);
    host.write_reg(A_CTL, 8'h00);
    quiet(5000);
    rd(A_FLG, 8'h10);
    host.write_reg(A_EXT, 8'h00);
    // calendar rollover through every counter except the year, frozen during access
    tb_fast <= 1'b1;
    host.set_time('{8'h59, 8'h59, 8'h23, 8'h40, 8'h28, 8'h02, 8'h01});
    cyc(64000);
    rd(A_SEC, 8'h59);
    host.access(1'b1);
    cyc(2000);
    rd(A_SEC, 8'h59);
    host.access(1'b0);
    cyc(20);
    rd(A_SEC, 8'h00);
    rd(A_MIN, 8'h00);
    rd(A_HOUR, 8'h00);
    rd(A_WDAY, 8'h01);
    rd(A_DAY, 8'h01);
    rd(A_MON, 8'h03);
    rd(A_YEAR, 8'h01);
    wrap_up();
  end
endmodule : tb
